// ### inc/sleep_ctrl_defs.vh
`ifndef SLEEP_CTRL_DEFS_VH
`define SLEEP_CTRL_DEFS_VH
// ------------------------------------------------------------
// register byte addresses on apb
// ------------------------------------------------------------
`define ADDR_POWER_REDUCTION_0 12'h064
`define ADDR_SLEEP_MODE_CONTROL 12'h068
`define ADDR_CORE_CONTROL 12'h06c
`define ADDR_SLEEP_STATUS 12'h070
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SMC_ARM_BIT 0
`define SMC_SEL_LSB 1
`define SMC_SEL_MSB 3
`define CC_UNLOCK_BIT 5
`define CC_BOD_OFF_BIT 6
`define CC_DEBUG_DIS_BIT 7
`define PR_CONVERTER 0
`define PR_SERIAL_ZERO 1
`define PR_SPI_PORT 2
`define PR_TIMER_ONE 3
`define PR_SERIAL_ONE 4
`define PR_TIMER_ZERO 5
`define PR_TIMER_TWO 6
`define PR_TWO_WIRE 7
// ------------------------------------------------------------
// sleep mode codes
// ------------------------------------------------------------
`define MODE_IDLE 3'h0
`define MODE_NOISE_RED 3'h1
`define MODE_POWER_DOWN 3'h2
`define MODE_POWER_SAVE 3'h3
`define MODE_RSVD_A 3'h4
`define MODE_RSVD_B 3'h5
`define MODE_STANDBY 3'h6
`define MODE_EXT_STANDBY 3'h7
// ------------------------------------------------------------
// reset values and timing counts
// ------------------------------------------------------------
`define RST_BYTE 8'h00
`define UNLOCK_WINDOW_CYC 3'h4
`define BOD_OFF_DELAY_CYC 3'h3
`define BOD_OFF_HOLD_CYC 3'h3
`define STANDBY_WAKE_CYC 8'h06
`define WAKE_HALT_CYC 8'h04
`define STARTUP_CYC_DEF 8'h10
`endif

// ### hdl/sleep_and_clock_gating_ctrl.v
`timescale 1ns/1ns
`include "sleep_ctrl_defs.vh"

// Behaviour
// - sleep select bits 3..1 decode idle, noise, down, save, two reserved, standby, ext
// - code 110 with crystal enters standby: power-down with oscillator, six cycle wake
// - code 111 with crystal enters extended standby: power-save with oscillator, six cycles
// - sleep instruction sleeps only while the arm bit is one
// - brown-out off bit set only by unlock write then plain write within four cycles
// - brown-out off bit active after three cycles, self-clears after three more
// - a set gate bit stops that peripheral clock and blocks its register access
// - clearing a gate bit restarts the clock with state preserved
// - gating acts in active and idle; deeper modes stop clocks anyway
// - power reduction register at 0x64 resets to zero, bit order as listed
// - timer two gate only acts while timer two is synchronous
// - an ungated timer continues exactly as before
// - enabled converter stays enabled in all sleep modes
// - comparator auto-off beyond idle and noise modes; reference kept if used
// - fuse-enabled brown-out stays on in idle and noise, and in deeper modes unless the off bit is active; enabled watchdog stays on in every sleep mode
// - input buffers off when io and converter clocks both stop, except wake pins
// - enabled debug keeps main clock in sleep; debug-disable bit turns debug off
// - reference kept on in sleep is ready at wake, else needs start-up time
// - idle stops only cpu and flash clocks; power-down stops all generated clocks but an async timer two peripheral clock
// - interrupt wake halts core four cycles beyond start-up then resumes
// - brown-out turned off for sleep is re-enabled on wake-up
module sleep_and_clock_gating_ctrl #(
    parameter STARTUP_CYC = `STARTUP_CYC_DEF
) (
    input  wire        clk_i,
    input  wire        srst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        sleep_instr_i,
    input  wire        wake_irq_i,
    input  wire        wake_reset_i,
    input  wire        crystal_sel_i,
    input  wire        timer_two_async_sel_i,
    input  wire        debug_enable_fuse_i,
    input  wire        scan_port_enable_fuse_i,
    input  wire        brownout_fuse_en_i,
    input  wire        converter_en_i,
    input  wire        comparator_en_i,
    input  wire        comparator_bandgap_i,
    input  wire        watchdog_en_i,
    output reg         cpu_halt_o,
    output reg         cpu_clk_en_o,
    output reg         io_clock_en_o,
    output reg         converter_clock_en_o,
    output reg         async_clk_en_o,
    output reg         main_osc_en_o,
    output reg  [7:0]  periph_clk_en_o,
    output reg  [7:0]  periph_access_ok_o,
    output reg         converter_keep_o,
    output reg         comparator_on_o,
    output reg         vref_on_o,
    output reg         vref_ready_o,
    output reg         brownout_on_o,
    output reg         watchdog_on_o,
    output reg         input_buf_en_o,
    output reg         debug_active_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam ST_RUN   = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_WAKE  = 2'h2;

    reg [7:0] power_reduction_0;
    reg [3:0] sleep_mode_control;
    reg       debug_disable;
    reg       unlock_pend;
    reg [2:0] unlock_cnt;
    reg       bod_off_set;
    reg       bod_off_active;
    reg [2:0] bod_off_cnt;
    reg [1:0] state;
    reg [2:0] mode;
    reg       bod_cut;
    reg [7:0] wake_cnt;
    reg       vref_in_sleep;

    wire       wr_en   = psel_i & penable_i & pwrite_i;
    wire [2:0] sel     = sleep_mode_control[`SMC_SEL_MSB:`SMC_SEL_LSB];
    wire       dbg_on  = debug_enable_fuse_i & scan_port_enable_fuse_i & ~debug_disable;
    wire       asleep  = (state == ST_SLEEP);

    // map a select code to the effective mode, reserved codes pass through unchanged
    function [2:0] eff_mode;
        input [2:0] code;
        input       xtal;
        begin
            case (code)
                `MODE_STANDBY:     eff_mode = xtal ? `MODE_STANDBY : `MODE_POWER_DOWN;
                `MODE_EXT_STANDBY: eff_mode = xtal ? `MODE_EXT_STANDBY
                                                   : `MODE_POWER_SAVE;
                default:           eff_mode = code;
            endcase
        end
    endfunction

    function is_rsvd;
        input [2:0] code;
        begin
            is_rsvd = (code == `MODE_RSVD_A) || (code == `MODE_RSVD_B);
        end
    endfunction

    // ------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            power_reduction_0  <= `RST_BYTE;
            sleep_mode_control <= 4'h0;
            debug_disable      <= 1'b0;
            unlock_pend        <= 1'b0;
            unlock_cnt         <= 3'h0;
            bod_off_set        <= 1'b0;
            pready_o           <= 1'b0;
            pslverr_o          <= 1'b0;
            prdata_o           <= 32'h0000_0000;
        end
        else
        begin
            pready_o    <= psel_i & ~penable_i;
            pslverr_o   <= 1'b0;
            bod_off_set <= 1'b0;
            if (unlock_pend)
            begin
                unlock_cnt <= unlock_cnt + 3'h1;
                if (unlock_cnt == `UNLOCK_WINDOW_CYC - 3'h1)
                    unlock_pend <= 1'b0;
            end
            if (psel_i & ~penable_i)
            begin
                case (paddr_i)
                    `ADDR_POWER_REDUCTION_0:  prdata_o <= {24'h0, power_reduction_0};
                    `ADDR_SLEEP_MODE_CONTROL: prdata_o <= {28'h0, sleep_mode_control};
                    `ADDR_CORE_CONTROL:       prdata_o <= {24'h0, debug_disable,
                                                 bod_off_active | bod_off_set,
                                                 unlock_pend, 5'h00};
                    `ADDR_SLEEP_STATUS:       prdata_o <= {27'h0, bod_cut, mode, asleep};
                    default:
                    begin
                        prdata_o  <= 32'h0000_0000;
                        pslverr_o <= ~pwrite_i;
                    end
                endcase
                if (pwrite_i && paddr_i != `ADDR_POWER_REDUCTION_0
                    && paddr_i != `ADDR_SLEEP_MODE_CONTROL && paddr_i != `ADDR_CORE_CONTROL)
                    pslverr_o <= 1'b1;
            end
            if (wr_en && pready_o)
            begin
                case (paddr_i)
                    `ADDR_POWER_REDUCTION_0:  power_reduction_0 <= pwdata_i[7:0];
                    `ADDR_SLEEP_MODE_CONTROL: sleep_mode_control <= pwdata_i[3:0];
                    `ADDR_CORE_CONTROL:
                    begin
                        debug_disable <= pwdata_i[`CC_DEBUG_DIS_BIT];
                        if (pwdata_i[`CC_BOD_OFF_BIT] & pwdata_i[`CC_UNLOCK_BIT])
                        begin
                            unlock_pend <= 1'b1;
                            unlock_cnt  <= 3'h0;
                        end
                        else if (pwdata_i[`CC_BOD_OFF_BIT] & unlock_pend)
                        begin
                            bod_off_set <= 1'b1;
                            unlock_pend <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // brown-out sleep-off timing
    // ------------------------------------------------------------
    // counts delay then active window after a successful set
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            bod_off_cnt    <= 3'h0;
            bod_off_active <= 1'b0;
        end
        else if (bod_off_set)
        begin
            bod_off_cnt    <= 3'h1;
            bod_off_active <= 1'b0;
        end
        else if (bod_off_cnt != 3'h0)
        begin
            if (!bod_off_active && bod_off_cnt == `BOD_OFF_DELAY_CYC)
            begin
                bod_off_active <= 1'b1;
                bod_off_cnt    <= 3'h1;
            end
            else if (bod_off_active && bod_off_cnt == `BOD_OFF_HOLD_CYC)
            begin
                bod_off_active <= 1'b0;
                bod_off_cnt    <= 3'h0;
            end
            else
                bod_off_cnt <= bod_off_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // sleep sequencer
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state         <= ST_RUN;
            mode          <= `MODE_IDLE;
            bod_cut       <= 1'b0;
            wake_cnt      <= 8'h00;
            vref_in_sleep <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (sleep_instr_i && sleep_mode_control[`SMC_ARM_BIT]
                        && !is_rsvd(sel))
                    begin
                        state   <= ST_SLEEP;
                        mode    <= eff_mode(sel, crystal_sel_i);
                        bod_cut <= bod_off_active && sel != `MODE_IDLE
                                   && sel != `MODE_NOISE_RED;
                        vref_in_sleep <= vref_on_o;
                    end
                end
                ST_SLEEP:
                begin
                    if (wake_irq_i || wake_reset_i)
                    begin
                        state   <= ST_WAKE;
                        bod_cut <= 1'b0;
                        if (mode == `MODE_STANDBY || mode == `MODE_EXT_STANDBY)
                            wake_cnt <= `STANDBY_WAKE_CYC;
                        else if (mode == `MODE_IDLE || mode == `MODE_NOISE_RED)
                            wake_cnt <= `WAKE_HALT_CYC;
                        else
                            wake_cnt <= STARTUP_CYC[7:0] + `WAKE_HALT_CYC;
                    end
                end
                ST_WAKE:
                begin
                    if (wake_cnt <= 8'h01)
                        state <= ST_RUN;
                    else
                        wake_cnt <= wake_cnt - 8'h01;
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock enables and module controls
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cpu_halt_o           <= 1'b0;
            cpu_clk_en_o         <= 1'b1;
            io_clock_en_o        <= 1'b1;
            converter_clock_en_o <= 1'b1;
            async_clk_en_o       <= 1'b1;
            main_osc_en_o        <= 1'b1;
            periph_clk_en_o      <= 8'hff;
            periph_access_ok_o   <= 8'hff;
            converter_keep_o     <= 1'b0;
            comparator_on_o      <= 1'b0;
            vref_on_o            <= 1'b0;
            vref_ready_o         <= 1'b0;
            brownout_on_o        <= 1'b0;
            watchdog_on_o        <= 1'b0;
            input_buf_en_o       <= 1'b1;
            debug_active_o       <= 1'b0;
        end
        else
        begin
            cpu_halt_o    <= (state != ST_RUN);
            cpu_clk_en_o  <= ~asleep;
            io_clock_en_o <= ~asleep || mode == `MODE_IDLE;
            converter_clock_en_o <= ~asleep || mode == `MODE_IDLE
                                    || mode == `MODE_NOISE_RED;
            async_clk_en_o <= ~asleep || mode != `MODE_POWER_DOWN
                              && mode != `MODE_STANDBY;
            main_osc_en_o <= ~asleep || mode == `MODE_IDLE || mode == `MODE_NOISE_RED
                             || mode == `MODE_STANDBY || mode == `MODE_EXT_STANDBY
                             || dbg_on;
            // gating applies while running or idle; deeper modes stop them anyway
            periph_clk_en_o <= (~asleep || mode == `MODE_IDLE) ?
                ~power_reduction_0 | {1'b0, timer_two_async_sel_i, 6'h00}
                : {1'b0, timer_two_async_sel_i, 6'h00};
            periph_access_ok_o <= ~power_reduction_0
                                  | {1'b0, timer_two_async_sel_i, 6'h00};
            converter_keep_o <= converter_en_i;
            comparator_on_o  <= comparator_en_i && (~asleep || mode == `MODE_IDLE
                                || mode == `MODE_NOISE_RED);
            vref_on_o <= brownout_fuse_en_i & ~bod_cut | converter_en_i
                         | comparator_en_i & comparator_bandgap_i;
            vref_ready_o <= (state == ST_WAKE) ? vref_in_sleep
                            : (vref_on_o & ~asleep);
            brownout_on_o  <= brownout_fuse_en_i & ~bod_cut;
            watchdog_on_o  <= watchdog_en_i;
            input_buf_en_o <= ~asleep || mode == `MODE_IDLE
                              || mode == `MODE_NOISE_RED;
            debug_active_o <= dbg_on;
        end
    end

endmodule // sleep_and_clock_gating_ctrl

// ### bench/sleep_ctrl_props.sv
`timescale 1ns/1ns
module sleep_ctrl_props (
    input wire        clk_i,
    input wire        srst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire [11:0] paddr_i,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        watchdog_en_i,
    input wire        watchdog_on_o,
    input wire        brownout_fuse_en_i,
    input wire        brownout_on_o,
    input wire        comparator_en_i,
    input wire        comparator_bandgap_i,
    input wire        comparator_on_o,
    input wire        vref_on_o,
    input wire        converter_en_i,
    input wire        converter_keep_o,
    input wire        debug_enable_fuse_i,
    input wire        scan_port_enable_fuse_i,
    input wire        debug_active_o,
    input wire        input_buf_en_o,
    input wire        io_clock_en_o,
    input wire        converter_clock_en_o,
    input wire [7:0]  periph_clk_en_o,
    input wire [7:0]  periph_access_ok_o
);
    // ----------------------------------------
    // helper: outputs are meaningful one edge after reset
    // ----------------------------------------
    reg run;
    always @(posedge clk_i)
    begin
        run <= !srst_i;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o && penable_i)
        else $error("pready missing after setup");
    a_err_unmapped: assert property (psel_i && !penable_i
        && !(paddr_i inside {12'h064, 12'h068, 12'h06c, 12'h070}) |=> pslverr_o)
        else $error("unmapped access not refused");
    // ----------------------------------------
    // gating and sleep keep-alive
    // ----------------------------------------
    // gate bits only matter while the io clock runs; deeper modes stop every peripheral clock but an async timer two anyway
    a_gated_no_access: assert property (io_clock_en_o
        |-> (periph_access_ok_o & ~periph_clk_en_o) == 8'h00)
        else $error("access allowed on gated peripheral");
    a_watchdog_kept: assert property (run |-> watchdog_on_o == $past(watchdog_en_i))
        else $error("watchdog state wrong");
    a_brownout_fuse: assert property (run && !$past(brownout_fuse_en_i) |-> !brownout_on_o)
        else $error("brownout on without fuse");
    a_converter_kept: assert property (run |-> converter_keep_o == $past(converter_en_i))
        else $error("converter keep wrong");
    a_vref_bandgap: assert property (run
        && $past(comparator_en_i && comparator_bandgap_i) |-> vref_on_o)
        else $error("reference dropped while used");
    a_comparator_off: assert property (run && !$past(comparator_en_i) |-> !comparator_on_o)
        else $error("comparator on while disabled");
    a_debug_fuses: assert property (run && $rose(debug_active_o)
        |-> $past(debug_enable_fuse_i && scan_port_enable_fuse_i))
        else $error("debug active without fuses");
    a_buf_off_clocks: assert property (run && !input_buf_en_o
        |-> !io_clock_en_o && !converter_clock_en_o)
        else $error("input buffers off with clocks running");
endmodule // sleep_ctrl_props

bind sleep_and_clock_gating_ctrl sleep_ctrl_props u_props (
    .clk_i, .srst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o,
    .watchdog_en_i, .watchdog_on_o, .brownout_fuse_en_i, .brownout_on_o,
    .comparator_en_i, .comparator_bandgap_i, .comparator_on_o, .vref_on_o,
    .converter_en_i, .converter_keep_o, .debug_enable_fuse_i, .scan_port_enable_fuse_i,
    .debug_active_o, .input_buf_en_o, .io_clock_en_o, .converter_clock_en_o,
    .periph_clk_en_o, .periph_access_ok_o
);

// ### bench/sleep_and_clock_gating_ctrl_tb.sv
`timescale 1ns/1ns
`include "sleep_ctrl_defs.vh"
module sleep_and_clock_gating_ctrl_tb;
    localparam int SU = 10;
    logic clk_i = 1'h0, srst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic sleep_instr_i = 1'h0, wake_irq_i = 1'h0, wake_reset_i = 1'h0, crystal_sel_i = 1'h1;
    logic timer_two_async_sel_i = 1'h0, debug_enable_fuse_i = 1'h0, scan_port_enable_fuse_i = 1'h0;
    logic brownout_fuse_en_i = 1'h1, converter_en_i = 1'h1, comparator_en_i = 1'h1;
    logic comparator_bandgap_i = 1'h1, watchdog_en_i = 1'h1;
    wire [31:0] prdata_o;
    wire [7:0]  periph_clk_en_o, periph_access_ok_o;
    wire pready_o, pslverr_o, cpu_halt_o, cpu_clk_en_o, io_clock_en_o, converter_clock_en_o;
    wire async_clk_en_o, main_osc_en_o, converter_keep_o, comparator_on_o, vref_on_o;
    wire vref_ready_o, brownout_on_o, watchdog_on_o, input_buf_en_o, debug_active_o;
    int mismatches = 0;
    int tests_run = 0;
    sleep_and_clock_gating_ctrl #(.STARTUP_CYC(SU)) dut (.clk_i, .srst_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sleep_instr_i,
        .wake_irq_i, .wake_reset_i, .crystal_sel_i, .timer_two_async_sel_i,
        .debug_enable_fuse_i, .scan_port_enable_fuse_i, .brownout_fuse_en_i, .converter_en_i,
        .comparator_en_i, .comparator_bandgap_i, .watchdog_en_i, .cpu_halt_o, .cpu_clk_en_o,
        .io_clock_en_o, .converter_clock_en_o, .async_clk_en_o, .main_osc_en_o,
        .periph_clk_en_o, .periph_access_ok_o, .converter_keep_o, .comparator_on_o, .vref_on_o,
        .vref_ready_o, .brownout_on_o, .watchdog_on_o, .input_buf_en_o, .debug_active_o);
    // ----------------------------------------
    // clock, shared tasks
    // ----------------------------------------
    always #25 clk_i = !clk_i;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel_i <= 1'h1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        // wait for the answer; only the bench watchdog ends a hang
        do @(posedge clk_i); while (pready_o !== 1'h1);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        // one idle edge so a following setup never re-drives psel in this time step
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'h1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        apb(1'h0, a, 32'h0, q, e);
        chk("read data", exp, q);
        chk("error flag", exp_err, e);
    endtask
    task automatic pulse_sleep();
        sleep_instr_i <= 1'h1;
        @(posedge clk_i);
        sleep_instr_i <= 1'h0;
        tick(2);
    endtask
    task automatic wake(input int w);
        int n;
        wake_irq_i <= 1'h1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (cpu_halt_o !== 1'h0 && n < 60);
        wake_irq_i <= 1'h0;
        // taken edge, w wake cycles, one output register stage, one sampling edge
        chk("wake cycles", w + 3, n);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(`ADDR_POWER_REDUCTION_0, 32'h0, 1'h0);
        rd(`ADDR_SLEEP_MODE_CONTROL, 32'h0, 1'h0);
        rd(12'h100, 32'h0, 1'h1);
        wr(`ADDR_SLEEP_STATUS, 32'hff);
        rd(`ADDR_SLEEP_STATUS, 32'h0, 1'h0);
        chk("clocks after reset", 8'hff, periph_clk_en_o);
        $display("done registers");
    endtask
    task automatic t_gate();
        logic [7:0] m;
        converter_en_i <= 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            m = ~(8'h01 << i);
            wr(`ADDR_POWER_REDUCTION_0, 32'h1 << i);
            tick(2);
            chk("gated clock", m, periph_clk_en_o);
            chk("gated access", m, periph_access_ok_o);
        end
        timer_two_async_sel_i <= 1'h1;
        wr(`ADDR_POWER_REDUCTION_0, 32'hff);
        rd(`ADDR_POWER_REDUCTION_0, 32'hff, 1'h0);
        chk("async timer clock", 8'h40, periph_clk_en_o);
        timer_two_async_sel_i <= 1'h0;
        converter_en_i <= 1'h1;
        wr(`ADDR_POWER_REDUCTION_0, 32'h0);
        tick(2);
        chk("ungated clocks", 8'hff, periph_clk_en_o);
        $display("done gating");
    endtask
    task automatic t_sleep(input logic [2:0] code, input logic arm, input logic xt);
        logic halt, osc;
        halt = arm && code != `MODE_RSVD_A && code != `MODE_RSVD_B;
        osc = !halt || code < 3'h2 || (code >= `MODE_STANDBY && xt);
        crystal_sel_i <= xt;
        wr(`ADDR_SLEEP_MODE_CONTROL, {28'h0, code, arm});
        pulse_sleep();
        chk("halted", halt, cpu_halt_o);
        chk("cpu clock", !halt, cpu_clk_en_o);
        chk("io clock", !halt || code == 3'h0, io_clock_en_o);
        chk("converter clock", !halt || code < 3'h2, converter_clock_en_o);
        chk("async clock", !halt || (code != `MODE_POWER_DOWN
            && code != `MODE_STANDBY), async_clk_en_o);
        chk("input buffers", !halt || code < 3'h2, input_buf_en_o);
        chk("oscillator", osc, main_osc_en_o);
        chk("comparator", !halt || code < 3'h2, comparator_on_o);
        chk("brownout kept", 1, brownout_on_o);
        if (halt)
            wake((code >= `MODE_STANDBY && xt) ? 6 : (code < 3'h2 ? 4 : SU + 4));
        wr(`ADDR_SLEEP_MODE_CONTROL, 32'h0);
        $display("done sleep code %0d arm %0d crystal %0d", code, arm, xt);
    endtask
    task automatic t_bod(input int gap, input logic exp_on);
        wr(`ADDR_SLEEP_MODE_CONTROL, {28'h0, `MODE_POWER_DOWN, 1'h1});
        wr(`ADDR_CORE_CONTROL, 32'h60);
        tick(gap);
        wr(`ADDR_CORE_CONTROL, 32'h40);
        tick(3);
        pulse_sleep();
        chk("brownout in sleep", exp_on, brownout_on_o);
        wake(SU + 4);
        chk("brownout after wake", 1, brownout_on_o);
        chk("reference ready", 1, vref_ready_o);
        rd(`ADDR_CORE_CONTROL, 32'h0, 1'h0);
        wr(`ADDR_SLEEP_MODE_CONTROL, 32'h0);
        $display("done brownout gap %0d", gap);
    endtask
    task automatic t_levels();
        watchdog_en_i <= 1'h0;
        converter_en_i <= 1'h0;
        comparator_en_i <= 1'h0;
        brownout_fuse_en_i <= 1'h0;
        debug_enable_fuse_i <= 1'h1;
        scan_port_enable_fuse_i <= 1'h1;
        tick(3);
        chk("watchdog", 0, watchdog_on_o);
        chk("converter keep", 0, converter_keep_o);
        chk("reference", 0, vref_on_o);
        chk("debug", 1, debug_active_o);
        wr(`ADDR_CORE_CONTROL, 32'h80);
        tick(2);
        chk("debug disabled", 0, debug_active_o);
        wr(`ADDR_CORE_CONTROL, 32'h0);
        watchdog_en_i <= 1'h1;
        converter_en_i <= 1'h1;
        comparator_en_i <= 1'h1;
        brownout_fuse_en_i <= 1'h1;
        debug_enable_fuse_i <= 1'h0;
        tick(3);
        chk("reference back", 1, vref_on_o);
        $display("done levels");
    endtask
    // ----------------------------------------
    // verdict, main sequence, watchdog
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        tick(8);
        srst_i <= 1'h0;
        t_regs();
        t_gate();
        for (int c = 0; c < 8; c++)
            t_sleep(c[2:0], 1'h1, 1'h1);
        t_sleep(`MODE_STANDBY, 1'h1, 1'h0);
        t_sleep(`MODE_EXT_STANDBY, 1'h1, 1'h0);
        t_sleep(`MODE_POWER_DOWN, 1'h0, 1'h1);
        t_bod(0, 1'h0);
        t_bod(5, 1'h1);
        t_levels();
        summarize();
    end
    initial
    begin
        #1000000;
        mismatches++;
        summarize();
    end
endmodule // sleep_and_clock_gating_ctrl_tb
